// File: inc/fst_params.svh
`ifndef FST_PARAMS_SVH
`define FST_PARAMS_SVH

// counter widths, buffer depth and timer count
`define FST_SUB_W         8
`define FST_CHIP_W        12
`define FST_SLOT_W        4
`define FST_FRM_W         12
`define FST_CPTR_W        3
`define FST_CBUF_N        8
`define FST_N_TMR         2

// event layout
`define FST_N_LINK        6
`define FST_N_XFER        4
`define FST_N_AIF_EV      13
`define FST_N_EV          17
`define FST_EV_FREF       0
`define FST_EV_4CHIP      1
`define FST_EV_PREP       7
`define FST_EV_XFER       13
`define FST_EV_EN_BIT     0
`define FST_EV_TSEL_BIT   1

// control register bits
`define FST_CTRL_RUN_LSB   0
`define FST_CTRL_BURST_LSB 2

// reset values of the wrap limits
`define FST_SUB_TC_RST    8'h1f
`define FST_CHIP_TC_RST   12'h9ff
`define FST_SLOT_TC_RST   4'he
`define FST_FRM_TC_RST    12'hfff

// byte addresses
`define FST_A_W           10
`define FST_A_CTRL        10'h000
`define FST_A_TMR         10'h010
`define FST_A_TMR_STRIDE  10'h020
`define FST_A_SUB_TC      10'h000
`define FST_A_SLOT_TC     10'h004
`define FST_A_FRM_TC      10'h008
`define FST_A_CBUF_LAST   10'h00c
`define FST_A_INIT        10'h010
`define FST_A_INIT_FRM    10'h014
`define FST_A_TIME        10'h018
`define FST_A_FRAME       10'h01c
`define FST_A_CBUF        10'h050
`define FST_A_CBUF_STRIDE 10'h020
`define FST_A_EV          10'h100
`define FST_A_EV_STRIDE   10'h010
`define FST_A_EV_VAL      10'h000
`define FST_A_EV_MASK     10'h004
`define FST_A_EV_CFG      10'h008

`endif

// File: inc/fst_pkg.sv
`include "fst_params.svh"

package fst_pkg;

  typedef struct packed {
    logic [`FST_FRM_W-1:0]  frame;
    logic [`FST_CPTR_W-1:0] cptr;
    logic [`FST_SLOT_W-1:0] slot;
    logic [`FST_CHIP_W-1:0] chip;
    logic [`FST_SUB_W-1:0]  sub;
  } fst_time_t;

  typedef struct packed {
    logic [`FST_SUB_W-1:0]                   sub_tc;
    logic [`FST_SLOT_W-1:0]                  slot_tc;
    logic [`FST_FRM_W-1:0]                   frame_tc;
    logic [`FST_CPTR_W-1:0]                  cbuf_last;
    logic [`FST_CBUF_N-1:0][`FST_CHIP_W-1:0] cbuf;
  } fst_tcfg_t;

  typedef struct packed {
    logic [31:0] value;
    logic [31:0] mask;
    logic        en;
    logic        tsel;
  } fst_evt_t;

  typedef struct packed {
    logic [3:0]                      ctrl;
    fst_time_t [`FST_N_TMR-1:0]      tmr;
    fst_tcfg_t [`FST_N_TMR-1:0]      tcfg;
    fst_evt_t  [`FST_N_EV-1:0]       evt;
    logic      [`FST_N_TMR-1:0]      adv;
    logic      [`FST_N_EV-1:0]       strb;
    logic                            ack;
    logic [31:0]                     rdata;
  } fst_state_t;

endpackage

// File: hdl/fst_frame_sync_timer.sv
// The Wishbone register port and the register addresses were left to the implementer.
`timescale 1ns/1ps

`include "fst_params.svh"

// Overview of operation
// [R1] thirteen distinct timing strobes to antenna interface
// [R2] MACs hold per-link receive/transmit offsets
// [R3] one common non-offset frame-reference strobe
// [R4] decoder and combiner paths get no strobes
// [R5] per-link prep and four-chip strobes, pre-aligned
// [R6] encoder builds one message group per strobe
// [R7] prep strobe every frame, ahead of transmit
// [R8] encoder ignores four-chip until prep seen
// [R9] extra events drive the external transfer engine
// [R10] software orders capture, transfer, build, transmit
// [R11] two timers, system and radio, identical
// [R12] sub-chip, chip, slot, frame sections
// [R13] each section wraps at written limit
// [R14] chip limit from circular buffer, last-entry depth
// [R15] buffer allows different chip counts per slot
// [R16] buffer position and timer visible to events
// [R17] independent wrap limits per timer
// [R18] count up to limit, then back to zero
// [R19] software loads initial counter values
// [R20] sync burst loads frame, clears other counters
// [R21] software writes limit as count minus one
// [R22] single buffer entry advised for wideband
// [R23] mask event fires on unmasked bit equality
// [R24] six per-link four-chip strobe events
// [R25] sections cascade sub-chip to chip to slot
// [R26] buffer pointer advances, wraps after last entry
module fst_frame_sync_timer
  import fst_pkg::*;
(
  // clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  // wishbone slave
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [`FST_A_W-1:0]      wb_adr_i,
  input  wire logic [31:0]              wb_dat_i,
  input  wire logic [3:0]               wb_sel_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  // timing reference
  input  wire logic                     ref_tick,
  input  wire logic                     sync_burst_valid,
  input  wire logic [`FST_FRM_W-1:0]    sync_burst_frame,
  // strobes
  output logic                          frame_reference_strobe,
  output logic      [`FST_N_LINK-1:0]   four_chip_strobe_out,
  output logic      [`FST_N_LINK-1:0]   link_frame_prep_strobe_out,
  output logic      [`FST_N_XFER-1:0]   transfer_event_out
);
  import fst_pkg::*;

  fst_state_t                 st;
  fst_state_t                 next_st;
  logic       [`FST_A_W-1:0]  adr;

  function automatic logic [31:0] fst_merge(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  sel);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_w[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // compare view: frame low bits, buffer position, slot, chip, sub-chip
  function automatic logic [31:0] fst_vec(input fst_time_t tm);
    return {tm.frame[4:0], tm.cptr, tm.slot, tm.chip, tm.sub};
  endfunction

  function automatic fst_state_t fst_reset_state();
    fst_state_t s;
    s = '0;
    for (int t = 0; t < `FST_N_TMR; t++) begin
      s.tcfg[t].sub_tc   = `FST_SUB_TC_RST;
      s.tcfg[t].slot_tc  = `FST_SLOT_TC_RST;
      s.tcfg[t].frame_tc = `FST_FRM_TC_RST;
      for (int k = 0; k < `FST_CBUF_N; k++) begin
        s.tcfg[t].cbuf[k] = `FST_CHIP_TC_RST;
      end
    end
    return s;
  endfunction

  localparam fst_state_t FST_RST = fst_reset_state();

  assign adr = {wb_adr_i[`FST_A_W-1:2], 2'b00};

  always_comb begin
    logic                   wr;
    logic [31:0]            rd;
    logic [31:0]            tv;
    logic [`FST_A_W-1:0]    tb;
    fst_time_t              tm;
    fst_tcfg_t              tc;
    wr = wb_cyc_i & wb_stb_i & wb_we_i & st.ack;
    rd = '0;
    tv = '0;
    tb = '0;
    tm = '0;
    tc = '0;
    next_st = st;
    // ack one cycle after the request, dropped the cycle after
    next_st.ack = wb_cyc_i & wb_stb_i & ~st.ack;

    if (adr == `FST_A_CTRL) begin
      rd = {28'h0000000, st.ctrl};
      if (wr) begin
        next_st.ctrl = 4'(fst_merge({28'h0000000, st.ctrl}, wb_dat_i,
                                    wb_sel_i));
      end
    end

    // both timers share one construction, each with its own limits
    for (int t = 0; t < `FST_N_TMR; t++) begin // [R11] [R17]
      tm = st.tmr[t];
      tc = st.tcfg[t];
      tb = `FST_A_W'(`FST_A_TMR + t * `FST_A_TMR_STRIDE);
      next_st.adv[t] = 1'b0;
      // sub-chip divides the reference tick
      if (st.ctrl[`FST_CTRL_RUN_LSB + t] && ref_tick) begin // [R12]
        next_st.adv[t] = 1'b1;
        if (tm.sub == tc.sub_tc) begin // [R13] [R18]
          tm.sub = '0;
          // chip limit comes from the circular buffer entry
          if (tm.chip == tc.cbuf[tm.cptr]) begin // [R14] [R15] [R25]
            tm.chip = '0;
            tm.cptr = (tm.cptr == tc.cbuf_last) ? '0 :
                      `FST_CPTR_W'(tm.cptr + 1'b1); // [R26]
            if (tm.slot == tc.slot_tc) begin // [R25]
              tm.slot = '0;
              tm.frame = (tm.frame == tc.frame_tc) ? '0 :
                         `FST_FRM_W'(tm.frame + 1'b1); // [R18]
            end else begin
              tm.slot = `FST_SLOT_W'(tm.slot + 1'b1);
            end
          end else begin
            tm.chip = `FST_CHIP_W'(tm.chip + 1'b1);
          end
        end else begin
          tm.sub = `FST_SUB_W'(tm.sub + 1'b1);
        end
      end

      // register access to this timer
      if (adr == tb + `FST_A_SUB_TC) begin
        rd = {24'h000000, tc.sub_tc};
        if (wr) begin
          tc.sub_tc = `FST_SUB_W'(fst_merge(32'(tc.sub_tc), wb_dat_i,
                                            wb_sel_i)); // [R13]
        end
      end
      if (adr == tb + `FST_A_SLOT_TC) begin
        rd = {28'h0000000, tc.slot_tc};
        if (wr) begin
          tc.slot_tc = `FST_SLOT_W'(fst_merge(32'(tc.slot_tc), wb_dat_i,
                                              wb_sel_i)); // [R13]
        end
      end
      if (adr == tb + `FST_A_FRM_TC) begin
        rd = {20'h00000, tc.frame_tc};
        if (wr) begin
          tc.frame_tc = `FST_FRM_W'(fst_merge(32'(tc.frame_tc), wb_dat_i,
                                              wb_sel_i)); // [R13]
        end
      end
      if (adr == tb + `FST_A_CBUF_LAST) begin
        rd = {29'h00000000, tc.cbuf_last};
        if (wr) begin
          tc.cbuf_last = `FST_CPTR_W'(fst_merge(32'(tc.cbuf_last),
                                                wb_dat_i, wb_sel_i)); // [R14]
        end
      end
      for (int k = 0; k < `FST_CBUF_N; k++) begin
        if (adr == `FST_A_W'(`FST_A_CBUF + t * `FST_A_CBUF_STRIDE + k * 4))
        begin
          rd = {20'h00000, tc.cbuf[k]};
          if (wr) begin
            tc.cbuf[k] = `FST_CHIP_W'(fst_merge(32'(tc.cbuf[k]), wb_dat_i,
                                                wb_sel_i)); // [R14]
          end
        end
      end
      // initial values: a load overrides the count in the same cycle
      if (adr == tb + `FST_A_INIT || adr == tb + `FST_A_TIME) begin
        rd = fst_vec(st.tmr[t]); // [R16]
        if (wr && adr == tb + `FST_A_INIT) begin
          tv = fst_merge(fst_vec(st.tmr[t]), wb_dat_i, wb_sel_i);
          tm.sub  = tv[7:0]; // [R19]
          tm.chip = tv[19:8];
          tm.slot = tv[23:20];
          tm.cptr = tv[26:24];
        end
      end
      if (adr == tb + `FST_A_INIT_FRM || adr == tb + `FST_A_FRAME) begin
        rd = {20'h00000, st.tmr[t].frame};
        if (wr && adr == tb + `FST_A_INIT_FRM) begin
          tm.frame = `FST_FRM_W'(fst_merge(32'(st.tmr[t].frame), wb_dat_i,
                                           wb_sel_i)); // [R19]
        end
      end
      // a received burst realigns the frame, everything else restarts
      if (sync_burst_valid && st.ctrl[`FST_CTRL_BURST_LSB + t]) begin
        tm = '0; // [R20]
        tm.frame = sync_burst_frame; // [R20]
      end
      next_st.tmr[t] = tm;
      next_st.tcfg[t] = tc;
    end

    // mask-based generators: 13 for the interface, rest for transfers
    for (int e = 0; e < `FST_N_EV; e++) begin // [R1] [R9] [R24]
      tb = `FST_A_W'(`FST_A_EV + e * `FST_A_EV_STRIDE);
      tv = fst_vec(st.tmr[st.evt[e].tsel]); // [R16]
      // all-zero mask disables; fires once per sub-chip position
      next_st.strb[e] = st.evt[e].en && st.adv[st.evt[e].tsel] &&
                        (st.evt[e].mask != '0) &&
                        (((tv ^ st.evt[e].value) & st.evt[e].mask) == '0);
      // [R23]
      if (adr == tb + `FST_A_EV_VAL) begin
        rd = st.evt[e].value;
        if (wr) begin
          next_st.evt[e].value = fst_merge(st.evt[e].value, wb_dat_i,
                                           wb_sel_i);
        end
      end
      if (adr == tb + `FST_A_EV_MASK) begin
        rd = st.evt[e].mask;
        if (wr) begin
          next_st.evt[e].mask = fst_merge(st.evt[e].mask, wb_dat_i,
                                          wb_sel_i);
        end
      end
      if (adr == tb + `FST_A_EV_CFG) begin
        rd = {30'h00000000, st.evt[e].tsel, st.evt[e].en};
        if (wr && wb_sel_i[0]) begin
          next_st.evt[e].en   = wb_dat_i[`FST_EV_EN_BIT];
          next_st.evt[e].tsel = wb_dat_i[`FST_EV_TSEL_BIT];
        end
      end
    end

    // read data captured with the rising ack; unmapped reads give zero
    if (next_st.ack) begin
      next_st.rdata = rd;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st <= FST_RST;
    end else begin
      st <= next_st;
    end
  end

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  // no strobe port toward decoder or combiner paths [R4]
  // one shared reference for both MACs, no offset applied here
  assign frame_reference_strobe = st.strb[`FST_EV_FREF]; // [R3]
  // per-link strobes already carry their own alignment
  assign four_chip_strobe_out =
    st.strb[`FST_EV_4CHIP +: `FST_N_LINK]; // [R5] [R24]
  assign link_frame_prep_strobe_out =
    st.strb[`FST_EV_PREP +: `FST_N_LINK]; // [R5] [R7]
  assign transfer_event_out = st.strb[`FST_EV_XFER +: `FST_N_XFER]; // [R9]

endmodule

// File: testbench/fst_frame_sync_timer_assertions.sv
`timescale 1ns/1ps
module fst_chk
(
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        reset_n,
  // bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // timing
  input wire logic        ref_tick,
  input wire logic        sync_burst_valid,
  // strobes
  input wire logic        frame_reference_strobe,
  input wire logic [5:0]  four_chip_strobe_out,
  input wire logic [5:0]  link_frame_prep_strobe_out,
  input wire logic [3:0]  transfer_event_out
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!reset_n);
  // strobes trail their timer step by two edges
  sequence step_2ago;
    $past(ref_tick, 2) || $past(sync_burst_valid, 2);
  endsequence
  bus_ack_delay_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  bus_ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  bus_ack_cause_a: assert property (
    wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  read_data_hold_a: assert property (
    !$stable(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved outside ack");
  frame_ref_cause_a: assert property (
    frame_reference_strobe |-> step_2ago)
    else $error("frame strobe without timer step");
  four_chip_cause_a: assert property (
    |four_chip_strobe_out |-> step_2ago)
    else $error("four-chip strobe without timer step");
  prep_cause_a: assert property (
    |link_frame_prep_strobe_out |-> step_2ago)
    else $error("prep strobe without timer step");
  xfer_cause_a: assert property (
    |transfer_event_out |-> step_2ago)
    else $error("transfer event without timer step");
endmodule

bind fst_frame_sync_timer fst_chk u_chk (.clk_sys(clk_sys),
  .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_tick(ref_tick),
  .sync_burst_valid(sync_burst_valid),
  .frame_reference_strobe(frame_reference_strobe),
  .four_chip_strobe_out(four_chip_strobe_out),
  .link_frame_prep_strobe_out(link_frame_prep_strobe_out),
  .transfer_event_out(transfer_event_out));

// File: testbench/fst_far_end.sv
`timescale 1ns/1ps
module fst_far_end
(
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       reset_n,
  // strobes from the timer
  input wire logic       frame_reference_strobe,
  input wire logic [5:0] four_chip_strobe_out,
  input wire logic [5:0] link_frame_prep_strobe_out,
  input wire logic [3:0] transfer_event_out,
  // tallies
  output int             cnt [17],
  output int             grp [6]
);
  // decoder side takes no strobes at all
  // every link's offsets count from the one frame reference
  logic [5:0]  armed;
  logic [16:0] ev;
  assign ev = {transfer_event_out, link_frame_prep_strobe_out,
               four_chip_strobe_out, frame_reference_strobe};
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      armed <= '0;
      cnt <= '{default: 0};
      grp <= '{default: 0};
    end else begin
      for (int e = 0; e < 17; e++)
        if (ev[e])
          cnt[e] <= cnt[e] + 1;
      for (int i = 0; i < 6; i++) begin
        if (four_chip_strobe_out[i] && armed[i])
          grp[i] <= grp[i] + 1;
        if (link_frame_prep_strobe_out[i])
          armed[i] <= 1'b1;
      end
    end
  end
endmodule

// File: testbench/fst_frame_sync_timer_bench.sv
`timescale 1ns/1ps
module fst_frame_sync_timer_bench;
  import fst_pkg::*;
  localparam int K = 22;
  // radio setup: sub 1, chips 2 then 4, last 1, slot 2, frame 3, run
  localparam logic [9:0]  CA[8] = '{10'h030, 10'h070, 10'h074, 10'h03c,
                                    10'h034, 10'h038, 10'h040, 10'h000};
  localparam logic [31:0] CD[8] = '{32'h1, 32'h2, 32'h4, 32'h1,
                                    32'h2, 32'h3, 32'h0, 32'h2};
  logic        clk_sys = 1'b0;
  logic        reset_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [9:0]  wb_adr_i = '0;
  logic [31:0] wb_dat_i = '0;
  logic [3:0]  wb_sel_i = 4'hf;
  logic        ref_tick = 1'b0;
  logic        sync_burst_valid = 1'b0;
  logic [11:0] sync_burst_frame = '0;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic        fref;
  logic [5:0]  four;
  logic [5:0]  prep;
  logic [3:0]  xfer;
  int          cnt [17];
  int          grp [6];
  int          err_count = 0;
  int          checks_done = 0;
  int          cyc_n = 0;
  int          n;
  logic [15:0] s = 16'h0016;
  logic [31:0] q;
  logic [31:0] r;
  fst_time_t   v;

  always #25 clk_sys = ~clk_sys;

  fst_frame_sync_timer uut (.clk_sys(clk_sys), .reset_n(reset_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ref_tick(ref_tick),
    .sync_burst_valid(sync_burst_valid),
    .sync_burst_frame(sync_burst_frame),
    .frame_reference_strobe(fref), .four_chip_strobe_out(four),
    .link_frame_prep_strobe_out(prep), .transfer_event_out(xfer));

  fst_far_end far (.clk_sys(clk_sys), .reset_n(reset_n),
    .frame_reference_strobe(fref), .four_chip_strobe_out(four),
    .link_frame_prep_strobe_out(prep), .transfer_event_out(xfer),
    .cnt(cnt), .grp(grp));

  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  function automatic fst_time_t step(input fst_time_t t);
    if (t.sub != 8'h1)
      t.sub++;
    else begin
      t.sub = '0;
      if (t.chip != (t.cptr[0] ? 12'h4 : 12'h2))
        t.chip++;
      else begin
        t.chip = '0;
        t.cptr = t.cptr ^ 3'h1;
        if (t.slot != 4'h2)
          t.slot++;
        else begin
          t.slot = '0;
          t.frame = (t.frame == 12'h3) ? '0 : t.frame + 12'h1;
        end
      end
    end
    return t;
  endfunction

  function automatic int cnt_exp(input int e);
    int c;
    c = 0;
    for (int j = 1; j <= K; j++)
      if (j % 4 == e % 4)
        c++;
    return c;
  endfunction

  // four-chip pulses count only after the link's first prep pulse
  function automatic int grp_exp(input int i);
    int j0;
    int c;
    j0 = 0;
    c = 0;
    for (int j = K; j >= 1; j--)
      if (j % 4 == (7 + i) % 4)
        j0 = j;
    for (int j = j0 + 1; j <= K; j++)
      if (j % 4 == (1 + i) % 4)
        c++;
    return c;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [9:0] a,
                    input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 50);
    q = wb_dat_o;
    if (t == 50)
      chk(1'b0, 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    wb(1'b0, a, '0);
    chk(q, e);
  endtask

  // random mode leaves gaps between ticks; otherwise one per cycle
  task automatic ticks(input int c, input logic rand_on);
    for (int i = 0; i < c; i++) begin
      @(posedge clk_sys);
      s = lfsr(s);
      ref_tick <= s[0] | ~rand_on;
      n += int'(s[0] | ~rand_on);
    end
    @(posedge clk_sys);
    ref_tick <= 1'b0;
  endtask

  task automatic print_verdict();
    if (err_count == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc_n++;
    if (cyc_n == 5000) begin
      err_count++;
      print_verdict();
    end
  end

  initial begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    rd(10'h010, 32'h1f);
    rd(10'h014, 32'he);
    rd(10'h038, 32'hfff);
    rd(10'h08c, 32'h9ff);
    rd(10'h01c, 32'h0);
    rd(10'h3fc, 32'h0);
    s = lfsr(s);
    r = {s, ~s};
    wb(1'b1, 10'h040, r);
    rd(10'h048, {5'h0, r[26:0]});
    for (int i = 0; i < 8; i++)
      wb(1'b1, CA[i], CD[i]);
    n = 0;
    ticks(200, 1'b1);
    wb(1'b1, 10'h000, 32'h0);
    v = '0;
    repeat (n) v = step(v);
    rd(10'h048, {v.frame[4:0], v[26:0]});
    rd(10'h010, 32'h1f);
    wb(1'b1, 10'h010, 32'h0);
    // non-zero start so the burst has counters to clear
    wb(1'b1, 10'h020, r);
    wb(1'b1, 10'h000, 32'h4);
    @(posedge clk_sys);
    sync_burst_valid <= 1'b1;
    sync_burst_frame <= s[11:0];
    @(posedge clk_sys);
    sync_burst_valid <= 1'b0;
    rd(10'h02c, {20'h0, s[11:0]});
    rd(10'h028, {s[4:0], 27'h0});
    rd(10'h048, {v.frame[4:0], v[26:0]});
    for (int e = 0; e < 17; e++) begin
      wb(1'b1, 10'h100 + 10'(16 * e), 32'(e % 4) << 8);
      wb(1'b1, 10'h104 + 10'(16 * e), 32'h300);
      wb(1'b1, 10'h108 + 10'(16 * e), 32'h1);
    end
    wb(1'b1, 10'h000, 32'h1);
    ticks(K, 1'b0);
    repeat (4) @(posedge clk_sys);
    for (int e = 0; e < 17; e++)
      chk(cnt[e], cnt_exp(e));
    for (int i = 0; i < 6; i++)
      chk(grp[i], grp_exp(i));
    print_verdict();
  end
endmodule
